//--- verilog/cesi_top.sv
// Error/status register, interrupt flags and buffer interrupt gating of a CAN controller.
// Assumes a protocol engine that gives one-cycle event pulses and level status on hclk,
// and a single AHB-Lite master for the register port.
`timescale 1ns/10ps
module cesi_top #(
    parameter int NUM_BUFFERS = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic soft_reset,
    input wire logic tx_bit_recessive,
    input wire logic rx_bit_dominant,
    input wire logic bit_check_strobe,
    input wire logic in_arbitration,
    input wire logic in_ack_slot,
    input wire logic sending_passive_flag,
    input wire logic ack_missing,
    input wire logic checksum_mismatch,
    input wire logic format_violation,
    input wire logic stuffing_violation,
    input wire logic [7:0] tx_err_count,
    input wire logic [7:0] rx_err_count,
    input wire logic bus_idle,
    input wire logic transmitting,
    input wire logic fault_passive,
    input wire logic fault_busoff,
    input wire logic low_power_mode,
    input wire logic can_rx,
    input wire logic [NUM_BUFFERS-1:0] buffer_done,
    output logic listen_only_enable,
    output logic busoff_irq,
    output logic error_irq,
    output logic wakeup_irq,
    output logic [NUM_BUFFERS-1:0] buffer_irq
);
    // Bus state
    logic ph_valid_q;
    logic ph_write_q;
    logic [11:0] ph_addr_q;
    logic addr_take;
    logic wr_status;
    logic wr_enable;
    logic wr_flags;
    logic wr_control;
    logic rd_status;
    // Register state
    logic [5:0] err_bits_q;
    logic [5:0] err_events;
    logic tx_warn_q;
    logic rx_warn_q;
    logic idle_q;
    logic dir_q;
    logic [1:0] fault_q;
    logic busoff_flag_q;
    logic error_flag_q;
    logic wakeup_flag_q;
    logic busoff_seen_q;
    logic can_rx_prev_q;
    logic wake_edge;
    logic [3:0] control_q;
    logic [NUM_BUFFERS-1:0] buf_enable_q;
    logic [NUM_BUFFERS-1:0] buf_flags;
    logic [NUM_BUFFERS-1:0] buf_irq_d;
    logic [31:0] status_word;
    logic [31:0] read_word;

    // Address phase capture; single word transfers only
    assign addr_take = hsel && hready &&
        (htrans == cesi_pkg::CESI_HTRANS_NONSEQ || htrans == cesi_pkg::CESI_HTRANS_SEQ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid_q <= 1'b0;
            ph_write_q <= 1'b0;
            ph_addr_q <= 12'h000;
        end else if (hready) begin
            ph_valid_q <= addr_take;
            ph_write_q <= hwrite;
            ph_addr_q <= {haddr[11:2], 2'b00};
        end
    end

    // Zero wait state slave, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Write strobes in the data phase, when hwdata stands
    assign wr_status = ph_valid_q && ph_write_q && (ph_addr_q == cesi_pkg::CESI_ADDR_STATUS);
    assign wr_enable = ph_valid_q && ph_write_q && (ph_addr_q == cesi_pkg::CESI_ADDR_BUF_ENABLE);
    assign wr_flags = ph_valid_q && ph_write_q && (ph_addr_q == cesi_pkg::CESI_ADDR_BUF_FLAGS);
    assign wr_control = ph_valid_q && ph_write_q && (ph_addr_q == cesi_pkg::CESI_ADDR_CONTROL);
    // Read of status is decided in the address phase so the data is registered
    assign rd_status = addr_take && !hwrite &&
        ({haddr[11:2], 2'b00} == cesi_pkg::CESI_ADDR_STATUS);

    // Error events; the readback fault is suppressed where the protocol allows it
    assign err_events[5] = bit_check_strobe && tx_bit_recessive && rx_bit_dominant &&
        !in_arbitration && !in_ack_slot && !sending_passive_flag;
    assign err_events[4] = bit_check_strobe && !tx_bit_recessive && !rx_bit_dominant;
    assign err_events[3] = ack_missing;
    assign err_events[2] = checksum_mismatch;
    assign err_events[1] = format_violation;
    assign err_events[0] = stuffing_violation;

    // Error bits: read clears, but an event in the same cycle survives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_bits_q <= 6'h00;
        end else if (soft_reset) begin
            err_bits_q <= 6'h00;
        end else if (rd_status) begin
            err_bits_q <= err_events;
        end else begin
            err_bits_q <= err_bits_q | err_events;
        end
    end

    // Level status, registered to keep read data and outputs glitch free
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_warn_q <= 1'b0;
            rx_warn_q <= 1'b0;
            idle_q <= 1'b1;
            dir_q <= 1'b0;
        end else begin
            tx_warn_q <= (tx_err_count >= cesi_pkg::CESI_WARN_LEVEL);
            rx_warn_q <= (rx_err_count >= cesi_pkg::CESI_WARN_LEVEL);
            idle_q <= bus_idle;
            dir_q <= transmitting;
        end
    end

    // Fault confinement; listen-only pins passive and rides through soft reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_q <= cesi_pkg::CESI_FAULT_ACTIVE;
        end else if (control_q[cesi_pkg::CESI_CTL_LOM_BIT]) begin
            fault_q <= cesi_pkg::CESI_FAULT_PASSIVE;
        end else if (soft_reset) begin
            fault_q <= cesi_pkg::CESI_FAULT_ACTIVE;
        end else if (fault_busoff) begin
            fault_q <= cesi_pkg::CESI_FAULT_BUSOFF;
        end else if (fault_passive) begin
            fault_q <= cesi_pkg::CESI_FAULT_PASSIVE;
        end else begin
            fault_q <= cesi_pkg::CESI_FAULT_ACTIVE;
        end
    end

    // Edge detectors for bus-off entry and wake-up falling edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busoff_seen_q <= 1'b0;
            can_rx_prev_q <= 1'b1;
        end else begin
            busoff_seen_q <= fault_busoff;
            can_rx_prev_q <= can_rx;
        end
    end

    // Recessive is high on the receive pin, so a falling edge is recessive to dominant
    assign wake_edge = low_power_mode && can_rx_prev_q && !can_rx;

    // Interrupt flags: set wins over a write-one clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busoff_flag_q <= 1'b0;
            error_flag_q <= 1'b0;
            wakeup_flag_q <= 1'b0;
        end else begin
            if (fault_busoff && !busoff_seen_q) begin
                busoff_flag_q <= 1'b1;
            end else if (wr_status && hwdata[cesi_pkg::CESI_BOFF_BIT]) begin
                busoff_flag_q <= 1'b0;
            end
            if (|err_events) begin
                error_flag_q <= 1'b1;
            end else if (wr_status && hwdata[cesi_pkg::CESI_ERRI_BIT]) begin
                error_flag_q <= 1'b0;
            end
            if (wake_edge) begin
                wakeup_flag_q <= 1'b1;
            end else if (wr_status && hwdata[cesi_pkg::CESI_WAKE_BIT]) begin
                wakeup_flag_q <= 1'b0;
            end
        end
    end

    // Control bits: interrupt enables and listen-only; survive soft reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_q <= cesi_pkg::CESI_CONTROL_RESET;
        end else if (wr_control) begin
            control_q <= hwdata[3:0];
        end
    end

    // Buffer enable register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buf_enable_q <= cesi_pkg::CESI_BUF_ENABLE_RESET[NUM_BUFFERS-1:0];
        end else if (wr_enable) begin
            buf_enable_q <= hwdata[NUM_BUFFERS-1:0];
        end
    end

    cesi_flag_bank #(
        .WIDTH(NUM_BUFFERS)
    ) u_flags (
        .hclk(hclk),
        .hresetn(hresetn),
        .set_pulse(buffer_done),
        .clear_we(wr_flags),
        .clear_data(hwdata[NUM_BUFFERS-1:0]),
        .enable(buf_enable_q),
        .flags_q(buf_flags),
        .irq_q(buf_irq_d)
    );

    // Three separate status requests, each gated by its own enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busoff_irq <= 1'b0;
            error_irq <= 1'b0;
            wakeup_irq <= 1'b0;
        end else begin
            busoff_irq <= busoff_flag_q && control_q[cesi_pkg::CESI_CTL_BOFF_EN_BIT];
            error_irq <= error_flag_q && control_q[cesi_pkg::CESI_CTL_ERR_EN_BIT];
            wakeup_irq <= wakeup_flag_q && control_q[cesi_pkg::CESI_CTL_WAKE_EN_BIT];
        end
    end

    // Buffer requests already registered inside the bank
    always_comb begin
        buffer_irq = buf_irq_d;
    end

    always_comb begin
        listen_only_enable = control_q[cesi_pkg::CESI_CTL_LOM_BIT];
    end

    // Status word; reserved bits tie to zero
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[15:10] = err_bits_q;
        status_word[cesi_pkg::CESI_TX_WARN_BIT] = tx_warn_q;
        status_word[cesi_pkg::CESI_RX_WARN_BIT] = rx_warn_q;
        status_word[cesi_pkg::CESI_IDLE_BIT] = idle_q;
        status_word[cesi_pkg::CESI_DIR_BIT] = dir_q;
        status_word[5:4] = fault_q;
        status_word[cesi_pkg::CESI_BOFF_BIT] = busoff_flag_q;
        status_word[cesi_pkg::CESI_ERRI_BIT] = error_flag_q;
        status_word[cesi_pkg::CESI_WAKE_BIT] = wakeup_flag_q;
    end

    // Read mux on the address phase; unmapped offsets read zero
    always_comb begin
        read_word = 32'h0000_0000;
        case ({haddr[11:2], 2'b00})
            cesi_pkg::CESI_ADDR_STATUS: begin
                read_word = status_word;
            end
            cesi_pkg::CESI_ADDR_BUF_ENABLE: begin
                read_word[NUM_BUFFERS-1:0] = buf_enable_q;
            end
            cesi_pkg::CESI_ADDR_BUF_FLAGS: begin
                read_word[NUM_BUFFERS-1:0] = buf_flags;
            end
            cesi_pkg::CESI_ADDR_CONTROL: begin
                read_word[3:0] = control_q;
            end
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
    end

    // Read data registered at the end of the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            hrdata <= read_word;
        end
    end
endmodule // cesi_top

//--- verilog/cesi_pkg.sv
// Constants for the CAN error, status and buffer interrupt block.
// Assumes an AHB-Lite slave with 32-bit data and single word transfers.
// Notes on behaviour
// - Error bits 15..10 hold events since the last status read; a read clears them.
// - Status logic drives three separate requests: bus-off, error and wake-up.
// - Bus-off, error, wake-up flags clear on write one; other fields read-only.
// - Bit 15 sets when a recessive bit sent reads back dominant.
// - Bit 15 is not raised in arbitration, ack slot or passive error flag.
// - Bit 14 sets when a dominant bit sent reads back recessive.
// - Bit 13 sets when a transmitter sees no dominant ack slot.
// - Bit 12 sets when a receiver finds a checksum mismatch.
// - Bit 11 sets when a receiver finds an illegal fixed-format bit.
// - Bit 10 sets on any bit-stuffing violation.
// - Bit 9 is one while transmit error count is at least 96.
// - Bit 8 is one while receive error count is at least 96.
// - Bit 7 is one while the bus is idle.
// - Bit 6 is one while transmitting, zero while receiving; meaningless when idle.
// - Bits 5..4: 00 error-active, 01 error-passive, 1x bus-off.
// - Listen-only forces error-passive; soft reset then leaves the field unchanged.
// - Bit 2 sets on bus-off entry; request while flag and enable set.
// - Bit 1 sets when any error bit sets; request while flag and enable set.
// - In doze or stop, a bus falling edge sets bit 0; enabled raises request.
// - Buffer enable register holds one enable bit per buffer 0 to 31.
// - Changing an enable bit changes that buffer's request one cycle later.
// - Completion event sets buffer flag; only a written one clears it.
// - A buffer request is raised while its flag and enable are both set.
package cesi_pkg;
    localparam logic [11:0] CESI_ADDR_STATUS = 12'h000;
    localparam logic [11:0] CESI_ADDR_BUF_ENABLE = 12'h004;
    localparam logic [11:0] CESI_ADDR_BUF_FLAGS = 12'h008;
    localparam logic [11:0] CESI_ADDR_CONTROL = 12'h00C;
    localparam int CESI_ERR_LSB = 10;
    localparam int CESI_TX_WARN_BIT = 9;
    localparam int CESI_RX_WARN_BIT = 8;
    localparam int CESI_IDLE_BIT = 7;
    localparam int CESI_DIR_BIT = 6;
    localparam int CESI_FAULT_LSB = 4;
    localparam int CESI_BOFF_BIT = 2;
    localparam int CESI_ERRI_BIT = 1;
    localparam int CESI_WAKE_BIT = 0;
    localparam int CESI_CTL_BOFF_EN_BIT = 0;
    localparam int CESI_CTL_ERR_EN_BIT = 1;
    localparam int CESI_CTL_WAKE_EN_BIT = 2;
    localparam int CESI_CTL_LOM_BIT = 3;
    localparam logic [7:0] CESI_WARN_LEVEL = 8'h60;
    localparam logic [31:0] CESI_BUF_ENABLE_RESET = 32'h0000_0000;
    localparam logic [3:0] CESI_CONTROL_RESET = 4'h0;
    localparam logic [1:0] CESI_FAULT_ACTIVE = 2'h0;
    localparam logic [1:0] CESI_FAULT_PASSIVE = 2'h1;
    localparam logic [1:0] CESI_FAULT_BUSOFF = 2'h2;
    localparam logic [1:0] CESI_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] CESI_HTRANS_SEQ = 2'h3;
endpackage

//--- verilog/cesi_flag_bank.sv
// Bank of sticky event flags with write-one-to-clear and a gating mask.
// Assumes set pulses and clear strobes synchronous to hclk.
`timescale 1ns/10ps
module cesi_flag_bank #(
    parameter int WIDTH = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] set_pulse,
    input wire logic clear_we,
    input wire logic [WIDTH-1:0] clear_data,
    input wire logic [WIDTH-1:0] enable,
    output logic [WIDTH-1:0] flags_q,
    output logic [WIDTH-1:0] irq_q
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // Set wins over a clear in the same cycle so no completion is lost
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    flags_q[i] <= 1'b0;
                end else if (set_pulse[i]) begin
                    flags_q[i] <= 1'b1;
                end else if (clear_we && clear_data[i]) begin
                    flags_q[i] <= 1'b0;
                end
            end
            // Request follows flag and enable, one register stage, no new event needed
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    irq_q[i] <= 1'b0;
                end else begin
                    irq_q[i] <= flags_q[i] & enable[i];
                end
            end
        end
    endgenerate
endmodule // cesi_flag_bank

//--- sim/cesi_top_props.sv
// Port-level checks of the CAN error, status and buffer interrupt block.
// Assumes one AHB-Lite master whose hready is the block's own hreadyout.
`timescale 1ns/10ps
module cesi_top_props #(
    parameter int NUM_BUFFERS = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic tx_bit_recessive,
    input wire logic rx_bit_dominant,
    input wire logic bit_check_strobe,
    input wire logic ack_missing,
    input wire logic checksum_mismatch,
    input wire logic format_violation,
    input wire logic stuffing_violation,
    input wire logic [7:0] tx_err_count,
    input wire logic [7:0] rx_err_count,
    input wire logic bus_idle,
    input wire logic fault_busoff,
    input wire logic low_power_mode,
    input wire logic can_rx,
    input wire logic [NUM_BUFFERS-1:0] buffer_done,
    input wire logic listen_only_enable,
    input wire logic busoff_irq,
    input wire logic error_irq,
    input wire logic wakeup_irq,
    input wire logic [NUM_BUFFERS-1:0] buffer_irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [2:0] err_sh, boff_sh, wake_sh, buf_sh;
    logic [3:0] wr_sh;
    logic fb_q, rx_q, err_ev;
    // Over-approximates the error causes; suppression only narrows them
    assign err_ev = ack_missing | checksum_mismatch | format_violation | stuffing_violation
        | (bit_check_strobe & (tx_bit_recessive == rx_bit_dominant));
    // Short cause history, so every raised request can be traced back
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {err_sh, boff_sh, wake_sh, buf_sh, wr_sh} <= '0;
            fb_q <= 1'b0;
            rx_q <= 1'b1;
        end else begin
            err_sh <= {err_sh[1:0], err_ev};
            boff_sh <= {boff_sh[1:0], fault_busoff & !fb_q};
            wake_sh <= {wake_sh[1:0], low_power_mode & rx_q & !can_rx};
            buf_sh <= {buf_sh[1:0], |buffer_done};
            wr_sh <= {wr_sh[2:0], hsel & hready & htrans[1] & hwrite};
            fb_q <= fault_busoff;
            rx_q <= can_rx;
        end
    end
    // Status read taken, then its data phase
    sequence s_status_rd;
        hsel && hready && htrans[1] && !hwrite && haddr == 12'h000 ##1 1'b1;
    endsequence
    a_warn_levels: assert property (s_status_rd |->
        hrdata[9] == ($past(tx_err_count, 2) >= 8'h60) && hrdata[7] == $past(bus_idle, 2)
        && hrdata[8] == ($past(rx_err_count, 2) >= 8'h60)) else $error("warning or idle bit");
    a_reserved_zero: assert property (s_status_rd |->
        hrdata[31:16] == 16'h0000 && !hrdata[3]) else $error("reserved status bits set");
    a_err_cause: assert property ($rose(error_irq) |-> (|err_sh) || (|wr_sh))
        else $error("error request without cause");
    a_boff_cause: assert property ($rose(busoff_irq) |-> (|boff_sh) || (|wr_sh))
        else $error("bus-off request without cause");
    a_wake_cause: assert property ($rose(wakeup_irq) |-> (|wake_sh) || (|wr_sh))
        else $error("wake-up request without cause");
    a_buf_cause: assert property ((buffer_irq & ~$past(buffer_irq)) != '0 |->
        (|buf_sh) || (|wr_sh)) else $error("buffer request without cause");
    a_buf_sticky: assert property (($past(buffer_irq) & ~buffer_irq) != '0 |-> |wr_sh)
        else $error("buffer request dropped without write");
    a_irq_sticky: assert property ($fell(busoff_irq) || $fell(error_irq)
        || $fell(wakeup_irq) |-> |wr_sh) else $error("status request dropped without write");
    a_lom_write: assert property ($changed(listen_only_enable) |-> wr_sh[1])
        else $error("listen-only changed without write");
endmodule // cesi_top_props
bind cesi_top cesi_top_props #(.NUM_BUFFERS(NUM_BUFFERS)) u_props (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hrdata, .tx_bit_recessive, .rx_bit_dominant,
    .bit_check_strobe, .ack_missing, .checksum_mismatch, .format_violation,
    .stuffing_violation, .tx_err_count, .rx_err_count, .bus_idle, .fault_busoff,
    .low_power_mode, .can_rx, .buffer_done, .listen_only_enable, .busoff_irq, .error_irq,
    .wakeup_irq, .buffer_irq);

//--- sim/cesi_can_node.sv
// Far side of the block: protocol engine events and bus levels.
// Assumes its tasks are called just after a rising edge of hclk.
`timescale 1ns/10ps
module cesi_can_node (
    input wire logic hclk,
    output logic tx_bit_recessive,
    output logic rx_bit_dominant,
    output logic bit_check_strobe,
    output logic in_arbitration,
    output logic in_ack_slot,
    output logic sending_passive_flag,
    output logic ack_missing,
    output logic checksum_mismatch,
    output logic format_violation,
    output logic stuffing_violation,
    output logic [7:0] tx_err_count,
    output logic [7:0] rx_err_count,
    output logic bus_idle,
    output logic transmitting,
    output logic fault_passive,
    output logic fault_busoff,
    output logic can_rx,
    output logic [31:0] buffer_done
);
    logic [9:0] ev = 10'h000;
    logic [20:0] lv = {16'h0000, 5'b10001};
    // Events are one-cycle pulses; levels hold until changed
    assign {ack_missing, checksum_mismatch, format_violation, stuffing_violation,
        tx_bit_recessive, rx_bit_dominant, in_arbitration, in_ack_slot,
        sending_passive_flag, bit_check_strobe} = ev;
    assign {tx_err_count, rx_err_count, bus_idle, transmitting, fault_passive,
        fault_busoff, can_rx} = lv;
    initial buffer_done = 32'h0000_0000;
    task automatic fire(input logic [9:0] v);
        ev <= v;
        @(posedge hclk);
        ev <= 10'h000;
    endtask
    task automatic levels(input logic [20:0] v);
        lv <= v;
    endtask
    // Bus is pulled recessive, so the dominant bit returns high
    task automatic wake();
        lv[0] <= 1'b0;
        @(posedge hclk);
        lv[0] <= 1'b1;
    endtask
    task automatic done(input logic [31:0] v);
        buffer_done <= v;
        @(posedge hclk);
        buffer_done <= 32'h0000_0000;
    endtask
endmodule // cesi_can_node

//--- sim/can_error_status_irq_tb.sv
// Self-checking bench of the CAN error, status and buffer interrupt block.
// Assumes the far-side model cesi_can_node and the bound port checker.
`timescale 1ns/10ps
module can_error_status_irq_tb;
    localparam logic [11:0] ST = cesi_pkg::CESI_ADDR_STATUS;
    localparam logic [11:0] EN = cesi_pkg::CESI_ADDR_BUF_ENABLE;
    localparam logic [11:0] FL = cesi_pkg::CESI_ADDR_BUF_FLAGS;
    localparam logic [11:0] CT = cesi_pkg::CESI_ADDR_CONTROL;
    logic hclk, hresetn, hsel, hwrite, soft_reset, low_power_mode;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, r, b;
    wire logic [31:0] hrdata, buffer_irq, buffer_done;
    wire logic hreadyout, hresp, listen_only_enable, busoff_irq, error_irq, wakeup_irq;
    wire logic tx_bit_recessive, rx_bit_dominant, bit_check_strobe, in_arbitration;
    wire logic in_ack_slot, sending_passive_flag, ack_missing, checksum_mismatch;
    wire logic format_violation, stuffing_violation, bus_idle, transmitting;
    wire logic fault_passive, fault_busoff, can_rx;
    wire logic [7:0] tx_err_count, rx_err_count;
    wire logic [31:0] irqs = {29'h0, busoff_irq, error_irq, wakeup_irq};
    int n_errors = 0;
    int comparisons = 0;
    // Event table: {ack, crc, form, stuff, tx, rx, arb, ack slot, passive, strobe}
    logic [9:0] evs [10] = '{10'h031, 10'h039, 10'h035, 10'h033, 10'h001, 10'h021,
        10'h200, 10'h100, 10'h080, 10'h040};
    logic [5:0] exps [10] = '{6'h20, 6'h00, 6'h00, 6'h00, 6'h10, 6'h00,
        6'h08, 6'h04, 6'h02, 6'h01};
    cesi_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .soft_reset, .tx_bit_recessive,
        .rx_bit_dominant, .bit_check_strobe, .in_arbitration, .in_ack_slot,
        .sending_passive_flag, .ack_missing, .checksum_mismatch, .format_violation,
        .stuffing_violation, .tx_err_count, .rx_err_count, .bus_idle, .transmitting,
        .fault_passive, .fault_busoff, .low_power_mode, .can_rx, .buffer_done,
        .listen_only_enable, .busoff_irq, .error_irq, .wakeup_irq, .buffer_irq);
    cesi_can_node can (.hclk, .tx_bit_recessive, .rx_bit_dominant, .bit_check_strobe,
        .in_arbitration, .in_ack_slot, .sending_passive_flag, .ack_missing,
        .checksum_mismatch, .format_violation, .stuffing_violation, .tx_err_count,
        .rx_err_count, .bus_idle, .transmitting, .fault_passive, .fault_busoff, .can_rx,
        .buffer_done);
    always #4 hclk = ~hclk;
    // Single transfer; no pipelining, so hrdata cannot move under the master
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= cesi_pkg::CESI_HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp,
            input logic [31:0] m = 32'hFFFF_FFFF);
        ahb(1'b0, a, 32'h0);
        chk(r & m, exp);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Cuts a hang short; the whole run needs a few hundred cycles
    initial begin
        #100us;
        n_errors++;
        give_verdict();
    end
    initial begin
        {hclk, hresetn, hsel, hwrite, soft_reset, low_power_mode} = '0;
        {haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(ST, 32'h80);
        rdc(EN, 32'h0);
        rdc(12'h010, 32'h0);
        chk({30'h0, hreadyout, hresp}, 32'h2);
        ahb(1'b1, CT, 32'h7);
        $display("test 1 done");
        for (int i = 0; i < 10; i++) begin
            can.fire(evs[i]);
            repeat (3) @(posedge hclk);
            b = {30'h0, |exps[i], 1'b0};
            chk(irqs, b);
            rdc(ST, {16'h0, exps[i], 10'h080} | b);
            ahb(1'b1, ST, 32'h0);
            rdc(ST, 32'h80 | b);
            ahb(1'b1, ST, 32'hFFFF_FFFF);
            rdc(ST, 32'h80);
        end
        fork
            ahb(1'b0, ST, 32'h0);
            can.fire(10'h200);
        join
        rdc(ST, 32'h2082);
        ahb(1'b1, ST, 32'h2);
        $display("test 2 done");
        can.levels({8'h5F, 8'h60, 5'b01101});
        repeat (3) @(posedge hclk);
        rdc(ST, 32'h150);
        can.levels({8'h60, 8'h5F, 5'b00011});
        repeat (3) @(posedge hclk);
        rdc(ST, 32'h224, 32'hFFFF_FFEF);
        chk(irqs, 32'h4);
        ahb(1'b1, ST, 32'h4);
        rdc(ST, 32'h220, 32'hFFFF_FFEF);
        chk(irqs, 32'h0);
        can.levels({16'h0, 5'b10001});
        ahb(1'b1, CT, 32'hF);
        // Control lands at the data-phase edge; let it and the fault field settle
        @(posedge hclk);
        chk({31'h0, listen_only_enable}, 32'h1);
        rdc(ST, 32'h90);
        soft_reset <= 1'b1;
        @(posedge hclk);
        soft_reset <= 1'b0;
        rdc(ST, 32'h90);
        rdc(CT, 32'hF);
        ahb(1'b1, CT, 32'h7);
        $display("test 3 done");
        can.wake();
        repeat (3) @(posedge hclk);
        rdc(ST, 32'h80);
        low_power_mode <= 1'b1;
        can.wake();
        repeat (3) @(posedge hclk);
        chk(irqs, 32'h1);
        rdc(ST, 32'h81);
        low_power_mode <= 1'b0;
        ahb(1'b1, ST, 32'h1);
        rdc(ST, 32'h80);
        $display("test 4 done");
        ahb(1'b1, EN, 32'hA5A5_0F0F);
        rdc(EN, 32'hA5A5_0F0F);
        can.done(32'hFFFF_FFFF);
        repeat (3) @(posedge hclk);
        chk(buffer_irq, 32'hA5A5_0F0F);
        rdc(FL, 32'hFFFF_FFFF);
        ahb(1'b1, EN, 32'hFFFF_0000);
        repeat (3) @(posedge hclk);
        chk(buffer_irq, 32'hFFFF_0000);
        ahb(1'b1, FL, 32'h0000_FFFF);
        rdc(FL, 32'hFFFF_0000);
        ahb(1'b1, FL, 32'hFFFF_FFFF);
        rdc(FL, 32'h0);
        chk(buffer_irq, 32'h0);
        $display("test 5 done");
        give_verdict();
    end
endmodule // can_error_status_irq_tb
